// ---- design/pcuc_pkg.sv ----
package pcuc_pkg;
   // ---------------------------------------------
   // register byte offsets
   // ---------------------------------------------
   localparam logic [7:0] MASK_OFS = 8'h00;
   localparam logic [7:0] ISTAT_OFS = 8'h04;
   localparam logic [7:0] IEN_OFS = 8'h08;
   localparam logic [7:0] ICLR_OFS = 8'h0C;
   localparam logic [7:0] FSTAT_OFS = 8'h10;
   // ---------------------------------------------
   // interrupt bit positions
   // ---------------------------------------------
   localparam int EV_EXPIRE = 0;
   localparam int EV_ABORT = 1;
   localparam int EV_RETRY = 2;
   localparam int EV_FULL = 3;
   localparam int EV_NUM = 4;
   // ---------------------------------------------
   // reset values and timing
   // ---------------------------------------------
   localparam logic [2:0] MASK_RST = 3'h7;
   localparam logic [3:0] IEN_RST = 4'h0;
   localparam int AEMPTY_LEVEL = 4;
   localparam int STAT_BITS = 3;
   localparam int DISC_BITS = 15;
   localparam int DISC_LIMIT = 32767;
   localparam logic [1:0] HTR_NONSEQ = 2'h2;
endpackage : pcuc_pkg

// ---- design/pcuc_core.sv ----
// Local design decisions: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module pcuc_core
   import pcuc_pkg::*;
#(
   parameter int DEPTH = 32,
   parameter int WORD_PARTS = 2,
   parameter int DISC_CNT = DISC_LIMIT
)(
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire logic        rdPush,
   input  wire logic        rdPushLast,
   input  wire logic        rdPopN,
   output logic             mst_rd_fifo_almost_empty_n,
   output logic             mst_rd_fifo_full_n,
   output logic             rdLastCycN,
   input  wire logic        stopBurstN,
   input  wire logic        burstActive,
   output logic             pciStopBurst,
   output logic             stop_release_full_flag_n,
   input  wire logic        tgtAbortReq,
   input  wire logic        tgtRetryN,
   input  wire logic        tgtDelayN,
   input  wire logic        tgtMemWrite,
   input  wire logic        tgtCycle,
   input  wire logic        dlyComplete,
   output logic             pciAbort,
   output logic             pciRetry,
   output logic             postedWrite,
   output logic             dlyStarted,
   output logic             dlyFresh,
   output logic             discExpiredN,
   input  wire logic [2:0]  statIn,
   input  wire logic        shiftSelN,
   output logic             statOut,
   output logic             irq
);
   localparam int CW = $clog2(DEPTH + 1);
   localparam int PW = $clog2(WORD_PARTS + 1);
   localparam logic [CW-1:0] FULLV = CW'(DEPTH);
   localparam logic [CW-1:0] AEV = CW'(AEMPTY_LEVEL);
   localparam logic [PW-1:0] LASTP = PW'(WORD_PARTS - 1);
   localparam logic [DISC_BITS-1:0] DLIM = DISC_BITS'(DISC_CNT);

   logic [CW-1:0]        cnt_ff, lastPos_ff, nxt_cnt;
   logic [PW-1:0]        part_ff;
   logic                 lastValid_ff;
   logic                 dlyRun_ff;
   logic [DISC_BITS-1:0] disc_ff;
   logic [1:0]           shIdx_ff;
   logic [2:0]           mask_ff;
   logic [EV_NUM-1:0]    istat_ff, ien_ff, evSet;
   logic                 wrPend_ff, rdPend_ff;
   logic [7:0]           wrAddr_ff;
   logic                 pop, push, wordDone, addrOk;

   // ---------------------------------------------
   // read fifo occupancy
   // ---------------------------------------------
   // pushes while full are dropped, pops on empty ignored
   assign push = rdPush && (cnt_ff != FULLV);
   assign pop = !rdPopN && (cnt_ff != '0);
   assign wordDone = pop && (part_ff == LASTP);
   always_comb begin
      nxt_cnt = cnt_ff;
      if (push && !wordDone)
         nxt_cnt = cnt_ff + CW'(1);
      else if (!push && wordDone)
         nxt_cnt = cnt_ff - CW'(1);
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cnt_ff <= '0;
         part_ff <= '0;
         mst_rd_fifo_almost_empty_n <= 1'b1;
         mst_rd_fifo_full_n <= 1'b1;
      end else begin
         cnt_ff <= nxt_cnt;
         if (pop)
            part_ff <= wordDone ? '0 : part_ff + PW'(1);
         mst_rd_fifo_almost_empty_n <= (nxt_cnt != AEV);
         mst_rd_fifo_full_n <= (nxt_cnt != FULLV);
      end
   end

   // ---------------------------------------------
   // last data marker
   // ---------------------------------------------
   // position of the final word counted from the head
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         lastValid_ff <= 1'b0;
         lastPos_ff <= '0;
         rdLastCycN <= 1'b1;
      end else begin
         rdLastCycN <= !(wordDone && lastValid_ff &&
                         lastPos_ff == CW'(1));
         if (push && rdPushLast) begin
            lastValid_ff <= 1'b1;
            lastPos_ff <= nxt_cnt;
         end else if (wordDone && lastValid_ff) begin
            lastValid_ff <= (lastPos_ff != CW'(1));
            lastPos_ff <= lastPos_ff - CW'(1);
         end
      end
   end

   // ---------------------------------------------
   // burst stop
   // ---------------------------------------------
   // release flag rises only once the pci burst has wound down
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pciStopBurst <= 1'b0;
         stop_release_full_flag_n <= 1'b1;
      end else begin
         pciStopBurst <= !stopBurstN && burstActive;
         if (!stopBurstN && burstActive)
            stop_release_full_flag_n <= 1'b0;
         else if (!burstActive)
            stop_release_full_flag_n <= 1'b1;
      end
   end

   // ---------------------------------------------
   // target abort, retry, posted and delayed
   // ---------------------------------------------
   // abort stays until reset since it covers all later cycles
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pciAbort <= 1'b0;
         pciRetry <= 1'b0;
         postedWrite <= 1'b0;
      end else begin
         if (tgtAbortReq)
            pciAbort <= 1'b1;
         pciRetry <= !tgtRetryN;
         postedWrite <= tgtCycle && tgtMemWrite;
      end
   end

   // ---------------------------------------------
   // discard timer
   // ---------------------------------------------
   // an expired entry is dropped; the next retry restarts it
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         dlyRun_ff <= 1'b0;
         disc_ff <= '0;
         dlyStarted <= 1'b0;
         dlyFresh <= 1'b0;
         discExpiredN <= 1'b1;
      end else begin
         dlyStarted <= 1'b0;
         dlyFresh <= 1'b0;
         if (tgtCycle && !tgtDelayN && !tgtMemWrite &&
             (!dlyRun_ff || !discExpiredN)) begin
            dlyRun_ff <= 1'b1;
            disc_ff <= '0;
            dlyStarted <= 1'b1;
            dlyFresh <= !discExpiredN;
            discExpiredN <= 1'b1;
         end else if (dlyRun_ff && dlyComplete) begin
            dlyRun_ff <= 1'b0;
         end else if (dlyRun_ff && discExpiredN) begin
            disc_ff <= disc_ff + DISC_BITS'(1);
            if (disc_ff == DLIM - DISC_BITS'(1))
               discExpiredN <= 1'b0;
         end
      end
   end

   // ---------------------------------------------
   // status output
   // ---------------------------------------------
   // bit 0 abort, 1 system error, 2 parity error
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         shIdx_ff <= '0;
         statOut <= 1'b0;
      end else if (shiftSelN) begin
         shIdx_ff <= '0;
         statOut <= |(statIn & mask_ff);
      end else begin
         statOut <= statIn[shIdx_ff];
         shIdx_ff <= (shIdx_ff == 2'(STAT_BITS - 1)) ?
                     '0 : shIdx_ff + 2'(1);
      end
   end

   // ---------------------------------------------
   // ahb-lite slave, zero wait states
   // ---------------------------------------------
   assign addrOk = hsel && htrans == HTR_NONSEQ && hready;
   assign evSet[EV_EXPIRE] = dlyRun_ff && discExpiredN &&
                             disc_ff == DLIM - DISC_BITS'(1);
   assign evSet[EV_ABORT] = tgtAbortReq && !pciAbort;
   assign evSet[EV_RETRY] = !tgtRetryN && !pciRetry;
   assign evSet[EV_FULL] = nxt_cnt == FULLV && cnt_ff != FULLV;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= '0;
         wrPend_ff <= 1'b0;
         rdPend_ff <= 1'b0;
         wrAddr_ff <= '0;
      end else begin
         wrPend_ff <= addrOk && hwrite;
         rdPend_ff <= addrOk && !hwrite;
         wrAddr_ff <= haddr[7:0];
         hrdata <= '0;
         if (addrOk && !hwrite) begin
            case (haddr[7:0])
               MASK_OFS:  hrdata <= {29'h0, mask_ff};
               ISTAT_OFS: hrdata <= {28'h0, istat_ff};
               IEN_OFS:   hrdata <= {28'h0, ien_ff};
               FSTAT_OFS: hrdata <= {16'h0, 8'(cnt_ff),
                  4'h0, discExpiredN, stop_release_full_flag_n,
                  mst_rd_fifo_full_n,
                  mst_rd_fifo_almost_empty_n};
               default:   hrdata <= '0;
            endcase
         end
      end
   end

   // register writes and sticky events, set beats clear
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         mask_ff <= MASK_RST;
         ien_ff <= IEN_RST;
         istat_ff <= '0;
         irq <= 1'b0;
      end else begin
         if (wrPend_ff && wrAddr_ff == MASK_OFS)
            mask_ff <= hwdata[2:0];
         if (wrPend_ff && wrAddr_ff == IEN_OFS)
            ien_ff <= hwdata[EV_NUM-1:0];
         if (wrPend_ff && wrAddr_ff == ICLR_OFS)
            istat_ff <= (istat_ff & ~hwdata[EV_NUM-1:0]) | evSet;
         else
            istat_ff <= istat_ff | evSet;
         irq <= |(istat_ff & ien_ff);
      end
   end

   // ---------------------------------------------
   // checks
   // ---------------------------------------------
   sequence s_stopReq;
      !stopBurstN && burstActive;
   endsequence
   sequence s_wordEnd;
      wordDone && lastValid_ff && lastPos_ff == CW'(1);
   endsequence

   a_aempty_level: assert property (@(posedge sys_clk) disable iff (rst)
      cnt_ff == AEV |=> !mst_rd_fifo_almost_empty_n || $changed(cnt_ff))
      else $error("almost empty flag wrong");
   a_full_flag: assert property (@(posedge sys_clk) disable iff (rst)
      !mst_rd_fifo_full_n |-> $past(nxt_cnt) == FULLV)
      else $error("full flag wrong");
   a_last_pulse: assert property (@(posedge sys_clk) disable iff (rst)
      s_wordEnd |=> !rdLastCycN ##1 (rdLastCycN || $past(wordDone)))
      else $error("last marker not one pulse");
   a_stop_release: assert property (@(posedge sys_clk) disable iff (rst)
      s_stopReq |=> !stop_release_full_flag_n && pciStopBurst)
      else $error("stop release flag did not drop");
   a_disc_expiry: assert property (@(posedge sys_clk) disable iff (rst)
      $fell(discExpiredN) |-> $past(disc_ff) == DLIM - DISC_BITS'(1))
      else $error("discard expiry at wrong count");
   a_fresh_retry: assert property (@(posedge sys_clk) disable iff (rst)
      dlyFresh |-> dlyStarted && $past(!discExpiredN))
      else $error("fresh retry without expiry");
   a_retry_follow: assert property (@(posedge sys_clk) disable iff (rst)
      !tgtRetryN ##1 !tgtRetryN |-> pciRetry)
      else $error("retry not signalled");
   a_posted_only: assert property (@(posedge sys_clk) disable iff (rst)
      dlyStarted |-> !$past(tgtMemWrite))
      else $error("memory write delayed");
   a_stat_or: assert property (@(posedge sys_clk) disable iff (rst)
      $past(shiftSelN) |-> statOut == |($past(statIn) & $past(mask_ff)))
      else $error("masked or wrong");
   a_stat_shift: assert property (@(posedge sys_clk) disable iff (rst)
      shiftSelN ##1 !shiftSelN |=> statOut == $past(statIn[0]))
      else $error("shift did not restart");
endmodule : pcuc_core

// ---- bench/pcuc_fabric_model.sv ----
`timescale 1ns/1ps
// ----------------------------------
// fabric target and master requests
// ----------------------------------
module pcuc_fabric_model (
   input  wire logic sys_clk,
   input  wire logic rst,
   input  wire logic goStop,
   input  wire logic goAbort,
   input  wire logic goRetry,
   input  wire logic goDelay,
   input  wire logic stop_release_full_flag_n,
   output logic      stopBurstN,
   output logic      tgtAbortReq,
   output logic      tgtRetryN,
   output logic      tgtDelayN
);
   logic [1:0] cnt_ff [4];
   logic [3:0] go;
   logic       stopOn_ff;
   assign go = {goDelay, goRetry, goAbort, goStop};
   // every request is held two clocks once raised, never shorter
   always_ff @(posedge sys_clk) begin
      for (int i = 0; i < 4; i++) begin
         if (rst) cnt_ff[i] <= 2'h0;
         else if (go[i]) cnt_ff[i] <= 2'h2;
         else if (cnt_ff[i] != 2'h0) cnt_ff[i] <= cnt_ff[i] - 2'h1;
      end
   end
   // stop waits for the release flag, which only rises late
   always_ff @(posedge sys_clk) begin
      if (rst) stopOn_ff <= 1'b0;
      else if (goStop) stopOn_ff <= 1'b1;
      else if (cnt_ff[0] == 2'h0 && stop_release_full_flag_n)
         stopOn_ff <= 1'b0;
   end
   assign stopBurstN  = !stopOn_ff;
   assign tgtAbortReq = cnt_ff[1] != 2'h0;
   assign tgtRetryN   = cnt_ff[2] == 2'h0;
   assign tgtDelayN   = cnt_ff[3] == 2'h0;
endmodule : pcuc_fabric_model

// ---- bench/pci_core_user_side_control_tb.sv ----
`timescale 1ns/1ps
module pci_core_user_side_control_tb
   import pcuc_pkg::*;
;
   localparam int DISC_SIM = 20;
   logic        sys_clk, rst, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [1:0]  htrans;
   logic        rdPush, rdPushLast, rdPopN, aeN, fullN, lastN;
   logic        stopBurstN, burstActive, pciStopBurst, relN;
   logic        tgtAbortReq, tgtRetryN, tgtDelayN, tgtMemWrite, tgtCycle;
   logic        pciAbort, pciRetry, postedWrite, dlyStarted, dlyFresh, expN;
   logic [2:0]  statIn, v;
   logic        shiftSelN, statOut, irq, goStop, goAbort, goRetry, goDelay;
   int          n_errors, samples_checked, m, s, e, f;
   assign hready = hreadyout;
   // ----------------------------------
   // design and fabric model
   // ----------------------------------
   pcuc_core #(.DISC_CNT(DISC_SIM)) dut_u (
      .sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .rdPush(rdPush), .rdPushLast(rdPushLast),
      .rdPopN(rdPopN), .mst_rd_fifo_almost_empty_n(aeN),
      .mst_rd_fifo_full_n(fullN), .rdLastCycN(lastN),
      .stopBurstN(stopBurstN), .burstActive(burstActive),
      .pciStopBurst(pciStopBurst), .stop_release_full_flag_n(relN),
      .tgtAbortReq(tgtAbortReq), .tgtRetryN(tgtRetryN),
      .tgtDelayN(tgtDelayN), .tgtMemWrite(tgtMemWrite),
      .tgtCycle(tgtCycle), .dlyComplete(1'b0), .pciAbort(pciAbort),
      .pciRetry(pciRetry), .postedWrite(postedWrite),
      .dlyStarted(dlyStarted), .dlyFresh(dlyFresh), .discExpiredN(expN),
      .statIn(statIn), .shiftSelN(shiftSelN), .statOut(statOut),
      .irq(irq));
   pcuc_fabric_model fab_u (
      .sys_clk(sys_clk), .rst(rst), .goStop(goStop), .goAbort(goAbort),
      .goRetry(goRetry), .goDelay(goDelay),
      .stop_release_full_flag_n(relN), .stopBurstN(stopBurstN),
      .tgtAbortReq(tgtAbortReq), .tgtRetryN(tgtRetryN),
      .tgtDelayN(tgtDelayN));
   // ----------------------------------
   // shared tasks
   // ----------------------------------
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // samples at the edge see values settled before it
   task tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : tick
   // one single transfer; entered right after an edge
   task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= HTR_NONSEQ; hwrite <= wr;
      do @(posedge sys_clk); while (hready !== 1'b1);
      htrans <= 2'h0; hsel <= 1'b0; hwdata <= d;
      do @(posedge sys_clk); while (hready !== 1'b1);
      q = hrdata;
      chk(hresp, 1'b0);                        // always an okay response
   endtask : ahb
   task give_verdict;
      if (n_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : give_verdict
   // ----------------------------------
   // scenarios
   // ----------------------------------
   task t_fifo;
      ahb(1'b0, MASK_OFS, 32'h0); chk(q, {29'h0, MASK_RST});
      ahb(1'b0, 8'h20, 32'h0); chk(q, 32'h0);
      rdPush <= 1'b1; tick(4); rdPush <= 1'b0;
      tick(2); chk(aeN, 1'b0);
      rdPush <= 1'b1; tick(27); rdPushLast <= 1'b1;
      tick(1); rdPushLast <= 1'b0;
      tick(1); rdPush <= 1'b0;                 // extra push dropped
      tick(2); chk(fullN, 1'b0);
      chk(aeN, 1'b1);
      chk(irq, 1'b0);                          // event not enabled
      ahb(1'b0, ISTAT_OFS, 32'h0); chk(q, 32'h8);
      ahb(1'b0, FSTAT_OFS, 32'h0); chk(q, 32'h0000200D);
      ahb(1'b1, IEN_OFS, 32'h8); tick(2); chk(irq, 1'b1);
      ahb(1'b1, ICLR_OFS, 32'h8); tick(2); chk(irq, 1'b0);
      m = 0; rdPopN <= 1'b0;
      for (int k = 0; k < 68; k++) begin
         tick(1);
         if (k == 63) rdPopN <= 1'b1;
         m += (lastN === 1'b0);
      end
      chk(m, 1);
      chk(fullN, 1'b1);
   endtask : t_fifo
   task t_stop;
      burstActive <= 1'b1; goStop <= 1'b1; tick(1); goStop <= 1'b0;
      tick(4); chk(pciStopBurst, 1'b1); chk(relN, 1'b0);
      burstActive <= 1'b0;
      tick(3); chk(relN, 1'b1); chk(pciStopBurst, 1'b0);
   endtask : t_stop
   // delayed start, then expiry after the discard count
   task dly(output int s, output int e, output int f);
      s = -1; e = -1; f = 0;
      tgtCycle <= 1'b1; goDelay <= 1'b1; tick(1); goDelay <= 1'b0;
      for (int k = 0; k < 40; k++) begin
         tick(1);
         if (k == 4) tgtCycle <= 1'b0;
         if (dlyStarted === 1'b1 && s < 0) s = k;
         // a flag left low by the previous expiry is not a new one
         if (expN === 1'b0 && e < 0 && s >= 0) e = k;
         f += (dlyFresh === 1'b1);
      end
   endtask : dly
   task t_tgt;
      tgtCycle <= 1'b1; tgtMemWrite <= 1'b1; goDelay <= 1'b1;
      tick(1); goDelay <= 1'b0; m = 0;
      repeat (4) begin tick(1); m += (dlyStarted === 1'b1); end
      chk(postedWrite, 1'b1); chk(m, 0);
      tgtCycle <= 1'b0; tgtMemWrite <= 1'b0; goRetry <= 1'b1;
      tick(1); goRetry <= 1'b0; tick(2); chk(pciRetry, 1'b1);
      dly(s, e, f); chk(e - s, DISC_SIM); chk(f, 0);
      dly(s, e, f); chk(f, 1); chk(e - s, DISC_SIM);
   endtask : t_tgt
   task t_stat;
      ahb(1'b1, MASK_OFS, 32'h3); statIn <= 3'h4;
      tick(3); chk(statOut, 1'b0);
      statIn <= 3'h6; tick(3); chk(statOut, 1'b1);
      repeat (2) begin
         shiftSelN <= 1'b0; tick(1);
         repeat (3) begin tick(1); v = {statOut, v[2:1]}; end
         chk(v, 3'h6);
         shiftSelN <= 1'b1; tick(2);
      end
      goAbort <= 1'b1; tick(1); goAbort <= 1'b0;
      tick(3); chk(pciAbort, 1'b1);
   endtask : t_stat
   // ----------------------------------
   // clock, reset, sequence, watchdog
   // ----------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   initial begin
      {rst, shiftSelN, rdPopN} = 3'h7;
      {hsel, hwrite, htrans, haddr, hwdata, rdPush, rdPushLast} = '0;
      {burstActive, tgtMemWrite, tgtCycle, statIn, v} = '0;
      {goStop, goAbort, goRetry, goDelay} = 4'h0;
      n_errors = 0; samples_checked = 0;
      tick(2); rst <= 1'b0; tick(1);
      t_fifo; t_stop; t_tgt; t_stat;
      give_verdict;
   end
   // whole run is under two thousand clocks
   initial begin
      #20000;
      n_errors++;
      give_verdict;
   end
endmodule : pci_core_user_side_control_tb
